// file: logic/dtc_pkg.sv
`default_nettype none
package dtc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NTMR   = 2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL  = 8'h88;
    localparam logic [7:0] IDX_MODE  = 8'h89;
    localparam logic [7:0] IDX_TL0   = 8'h8a;
    localparam logic [7:0] IDX_TL1   = 8'h8b;
    localparam logic [7:0] IDX_TH0   = 8'h8c;
    localparam logic [7:0] IDX_TH1   = 8'h8d;
    localparam logic [7:0] IDX_CKDIV = 8'h8e;
    localparam logic [7:0] IDX_ISTAT = 8'h90;
    localparam logic [7:0] IDX_IMASK = 8'h91;
    localparam logic [7:0] IDX_CKSPD = 8'h96;
    localparam logic [7:0] IDX_PWR   = 8'h97;

    // Field positions
    localparam int CTRL_RUN_LSB  = 4;
    localparam int CTRL_FLAG_LSB = 5;
    localparam int MODE_STRIDE   = 4;
    localparam int MODE_CT       = 2;
    localparam int MODE_GATE     = 3;
    localparam int CK_SEL_LSB    = 3;
    localparam int PWR_DIV_LSB   = 6;

    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [1:0] RST_ISTAT    = 2'h0;
    localparam logic [3:0] EDGE_PATTERN = 4'hc;
    localparam logic [1:0] PWR_DIV_1024 = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // Clock counts per timer tick
    localparam int TICK_W        = 12;
    localparam int DIV_FAST      = 1;
    localparam int DIV_QUARTER   = 4;
    localparam int DIV_STD       = 12;
    localparam int DIV_PM_SEL    = 1024;
    localparam int DIV_PM_SLOW   = 3072;

    typedef enum logic [1:0] {
        MODE_13     = 2'b00,
        MODE_16     = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_STOP   = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic [1:0] pwr_div;
        logic       fast_sel;
        logic       div_sel;
    } dtc_tcfg_t;
endpackage
`default_nettype wire

// file: logic/dtc_tick.sv
`default_nettype none
module dtc_tick #(
    parameter int CNT_W = dtc_pkg::TICK_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire dtc_pkg::dtc_tcfg_t i_cfg,
    output logic                   o_tick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last;

    // Period pick; power state takes precedence, and the select bits then choose 1024 or 3072 clocks
    always_comb begin
        if (i_cfg.pwr_div == dtc_pkg::PWR_DIV_1024) begin
            last = (i_cfg.fast_sel || i_cfg.div_sel)
                 ? CNT_W'(dtc_pkg::DIV_PM_SEL - 1)
                 : CNT_W'(dtc_pkg::DIV_PM_SLOW - 1);
        end else if (i_cfg.fast_sel) begin
            last = CNT_W'(dtc_pkg::DIV_FAST - 1);
        end else if (i_cfg.div_sel) begin
            last = CNT_W'(dtc_pkg::DIV_QUARTER - 1);
        end else begin
            last = CNT_W'(dtc_pkg::DIV_STD - 1);
        end
    end

    // Greater-or-equal so a shorter period never strands the count
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r <= '0;
        end else if (cnt_r >= last) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    assign o_tick = (cnt_r >= last);

    AST_TICK_FAST: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $stable(i_cfg) && i_cfg.fast_sel && i_cfg.pwr_div != dtc_pkg::PWR_DIV_1024
        |-> o_tick && $past(o_tick))
        else $error("fast select must tick every clock");
    AST_TICK_PM: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_tick && i_cfg.pwr_div == dtc_pkg::PWR_DIV_1024 && $stable(i_cfg)
        |=> !o_tick || i_cfg != $past(i_cfg))
        else $error("power state tick came too soon");
endmodule // dtc_tick
`default_nettype wire

// file: logic/dtc_top.sv
`default_nettype none
module dtc_top (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [dtc_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    input  wire logic [dtc_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    output logic [1:0]                      o_bresp,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    input  wire logic [dtc_pkg::ADDR_W-1:0] i_araddr,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    output logic [dtc_pkg::DATA_W-1:0]      o_rdata,
    output logic [1:0]                      o_rresp,
    input  wire logic                       i_first_gate_pin,
    input  wire logic                       i_second_gate_pin,
    input  wire logic                       i_first_count_pin,
    input  wire logic                       i_second_count_pin,
    input  wire logic [1:0]                 i_ovf_ack,
    output logic [1:0]                      o_ovf_flag,
    output logic                            o_irq
);
    localparam int N = dtc_pkg::NTMR;

    // Register file
    logic [7:0] ctrl_r, mode_r, ckdiv_r, ckspd_r, pwr_r;
    logic [1:0] istat_r, imask_r;
    logic [7:0] tl_r [N];
    logic [7:0] th_r [N];

    // Bus state
    logic                       aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [dtc_pkg::ADDR_W-1:0] awaddr_r;
    logic [7:0]                 wdata_r;
    logic                       wstrb_r;
    logic [1:0]                 bresp_r, rresp_r;
    logic [7:0]                 rdata_r;

    // Per-timer signals
    logic [N-1:0] gate_pin, count_pin, run, inc, ovf, tick;
    logic [3:0]   hist_r [N];
    logic [7:0]   tl_nxt [N];
    logic [7:0]   th_nxt [N];
    dtc_pkg::dtc_mode_t mode [N];
    dtc_pkg::dtc_tcfg_t tcfg [N];

    // Index decode shared by read and write paths
    function automatic logic [8:0] dtc_decode(input logic [dtc_pkg::ADDR_W-1:0] a);
        dtc_decode = {(a[1:0] == 2'h0) && (a[11:10] == 2'h0), a[9:2]};
    endfunction

    assign gate_pin  = {i_second_gate_pin, i_first_gate_pin};
    assign count_pin = {i_second_count_pin, i_first_count_pin};

    // Write channel; address and data accepted in either order
    logic       aw_hs, w_hs, do_wr;
    logic [8:0] wdec;
    logic [dtc_pkg::ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_en;
    assign o_awready = !aw_held_r && !bvalid_r;
    assign o_wready  = !w_held_r && !bvalid_r;
    assign aw_hs     = i_awvalid && o_awready;
    assign w_hs      = i_wvalid && o_wready;
    assign do_wr     = (aw_held_r || aw_hs) && (w_held_r || w_hs);
    assign wr_addr   = aw_held_r ? awaddr_r : i_awaddr;
    assign wr_data   = w_held_r ? wdata_r : i_wdata[7:0];
    assign wr_en     = w_held_r ? wstrb_r : i_wstrb[0];
    assign wdec      = dtc_decode(wr_addr);

    // Write strobes per register
    logic wr_ctrl, wr_mode, wr_ckdiv, wr_ckspd, wr_pwr, wr_imask, wr_hit;
    logic [N-1:0] wr_tl, wr_th;
    always_comb begin
        {wr_ctrl, wr_mode, wr_ckdiv, wr_ckspd, wr_pwr, wr_imask} = '0;
        wr_tl    = '0;
        wr_th    = '0;
        wr_hit   = wdec[8];
        if (!wdec[8]) begin
            wr_hit = 1'b0;
        end else if (wdec[7:0] == dtc_pkg::IDX_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_MODE) begin
            wr_mode = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_TL0) begin
            wr_tl[0] = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_TL1) begin
            wr_tl[1] = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_TH0) begin
            wr_th[0] = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_TH1) begin
            wr_th[1] = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_CKDIV) begin
            wr_ckdiv = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_CKSPD) begin
            wr_ckspd = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_PWR) begin
            wr_pwr = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_IMASK) begin
            wr_imask = 1'b1;
        end else if (wdec[7:0] == dtc_pkg::IDX_ISTAT) begin
            wr_hit = 1'b1; // Read-to-clear only; writes ignored
        end else begin
            wr_hit = 1'b0;
        end
        if (!(do_wr && wr_en)) begin
            {wr_ctrl, wr_mode, wr_ckdiv, wr_ckspd, wr_pwr, wr_imask} = '0;
            wr_tl = '0;
            wr_th = '0;
        end
    end

    // Write channel holding and response
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= dtc_pkg::RST_BYTE;
            wstrb_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= dtc_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) awaddr_r <= i_awaddr;
            if (w_hs) begin
                wdata_r <= i_wdata[7:0];
                wstrb_r <= i_wstrb[0];
            end
            if (do_wr) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
            end else begin
                aw_held_r <= aw_held_r || aw_hs;
                w_held_r  <= w_held_r || w_hs;
                if (i_bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end
    assign o_bvalid = bvalid_r;
    assign o_bresp  = bresp_r;

    // Read mux
    logic       ar_hs, rd_hit;
    logic [8:0] rdec;
    logic [7:0] rd_val;
    assign o_arready = !rvalid_r;
    assign ar_hs     = i_arvalid && o_arready;
    assign rdec      = dtc_decode(i_araddr);
    always_comb begin
        rd_val = dtc_pkg::RST_BYTE;
        rd_hit = 1'b1;
        if (!rdec[8]) begin
            rd_hit = 1'b0;
        end else if (rdec[7:0] == dtc_pkg::IDX_CTRL) begin
            rd_val = ctrl_r;
        end else if (rdec[7:0] == dtc_pkg::IDX_MODE) begin
            rd_val = mode_r;
        end else if (rdec[7:0] == dtc_pkg::IDX_TL0) begin
            rd_val = tl_r[0];
        end else if (rdec[7:0] == dtc_pkg::IDX_TL1) begin
            rd_val = tl_r[1];
        end else if (rdec[7:0] == dtc_pkg::IDX_TH0) begin
            rd_val = th_r[0];
        end else if (rdec[7:0] == dtc_pkg::IDX_TH1) begin
            rd_val = th_r[1];
        end else if (rdec[7:0] == dtc_pkg::IDX_CKDIV) begin
            rd_val = ckdiv_r;
        end else if (rdec[7:0] == dtc_pkg::IDX_CKSPD) begin
            rd_val = ckspd_r;
        end else if (rdec[7:0] == dtc_pkg::IDX_PWR) begin
            rd_val = pwr_r;
        end else if (rdec[7:0] == dtc_pkg::IDX_ISTAT) begin
            rd_val = {6'h00, istat_r};
        end else if (rdec[7:0] == dtc_pkg::IDX_IMASK) begin
            rd_val = {6'h00, imask_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read response, one cycle after address taken
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= dtc_pkg::RST_BYTE;
            rresp_r  <= dtc_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_r;
    assign o_rdata  = {24'h000000, rdata_r};
    assign o_rresp  = rresp_r;

    // Plain configuration registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_r  <= dtc_pkg::RST_BYTE;
            ckdiv_r <= dtc_pkg::RST_BYTE;
            ckspd_r <= dtc_pkg::RST_BYTE;
            pwr_r   <= dtc_pkg::RST_BYTE;
            imask_r <= dtc_pkg::RST_ISTAT;
        end else begin
            if (wr_mode)  mode_r  <= wr_data;
            if (wr_ckdiv) ckdiv_r <= wr_data;
            if (wr_ckspd) ckspd_r <= wr_data;
            if (wr_pwr)   pwr_r   <= wr_data;
            if (wr_imask) imask_r <= wr_data[1:0];
        end
    end
    // Per-timer control decode, time base and count-pin filter
    for (genvar n = 0; n < N; n++) begin : g_tmr
        assign mode[n] = dtc_pkg::dtc_mode_t'(mode_r[n*dtc_pkg::MODE_STRIDE +: 2]);
        assign run[n]  = ctrl_r[dtc_pkg::CTRL_RUN_LSB + 2*n];
        assign tcfg[n] = '{pwr_div:  pwr_r[dtc_pkg::PWR_DIV_LSB +: 2],
                           fast_sel: ckspd_r[dtc_pkg::CK_SEL_LSB + n],
                           div_sel:  ckdiv_r[dtc_pkg::CK_SEL_LSB + n]};
        dtc_tick u_tick (
            .i_clk  (i_clk),
            .i_nrst (i_nrst),
            .i_cfg  (tcfg[n]),
            .o_tick (tick[n])
        );
        // Two high then two low samples make one count
        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                hist_r[n] <= 4'h0;
            end else begin
                hist_r[n] <= {hist_r[n][2:0], count_pin[n]};
            end
        end
        // Gate qualifies run; source is tick or filtered pin edge
        assign inc[n] = run[n]
            && (!mode_r[n*dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_GATE] || gate_pin[n])
            && (mode_r[n*dtc_pkg::MODE_STRIDE + dtc_pkg::MODE_CT]
                ? (hist_r[n] == dtc_pkg::EDGE_PATTERN) : tick[n]);
    end

    // Next count per mode
    always_comb begin
        logic [12:0] c13;
        logic [15:0] c16;
        c13 = '0;
        c16 = '0;
        for (int n = 0; n < N; n++) begin
            tl_nxt[n] = tl_r[n];
            th_nxt[n] = th_r[n];
            ovf[n]    = 1'b0;
            c13 = {th_r[n], tl_r[n][4:0]} + 13'h0001;
            c16 = {th_r[n], tl_r[n]} + 16'h0001;
            case (mode[n])
                dtc_pkg::MODE_13: begin
                    {th_nxt[n], tl_nxt[n][4:0]} = c13;
                    ovf[n] = (c13 == 13'h0000);
                end
                dtc_pkg::MODE_16: begin
                    {th_nxt[n], tl_nxt[n]} = c16;
                    ovf[n] = (c16 == 16'h0000);
                end
                dtc_pkg::MODE_RELOAD: begin
                    ovf[n]    = (tl_r[n] == 8'hff);
                    tl_nxt[n] = ovf[n] ? th_r[n] : tl_r[n] + 8'h01;
                end
                default: begin
                    ovf[n] = 1'b0; // Stopped mode holds its value
                end
            endcase
            ovf[n] = ovf[n] && inc[n];
        end
    end

    // Count bytes; a software write beats a same-cycle count
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int n = 0; n < N; n++) begin
                tl_r[n] <= dtc_pkg::RST_BYTE;
                th_r[n] <= dtc_pkg::RST_BYTE;
            end
        end else begin
            for (int n = 0; n < N; n++) begin
                if (inc[n]) begin
                    tl_r[n] <= tl_nxt[n];
                    th_r[n] <= th_nxt[n];
                end
                if (wr_tl[n]) tl_r[n] <= wr_data;
                if (wr_th[n]) th_r[n] <= wr_data;
            end
        end
    end

    // Control flags; hardware set wins over write or acknowledge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_r <= dtc_pkg::RST_BYTE;
        end else begin
            if (wr_ctrl) ctrl_r <= wr_data;
            for (int n = 0; n < N; n++) begin
                if (i_ovf_ack[n]) ctrl_r[dtc_pkg::CTRL_FLAG_LSB + 2*n] <= 1'b0;
                if (ovf[n]) ctrl_r[dtc_pkg::CTRL_FLAG_LSB + 2*n] <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, cleared by reading it
    logic rd_istat;
    assign rd_istat = ar_hs && rdec[8] && rdec[7:0] == dtc_pkg::IDX_ISTAT;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            istat_r <= dtc_pkg::RST_ISTAT;
        end else begin
            istat_r <= (rd_istat ? 2'h0 : istat_r) | ovf;
        end
    end

    assign o_ovf_flag = {ctrl_r[dtc_pkg::CTRL_FLAG_LSB + 2], ctrl_r[dtc_pkg::CTRL_FLAG_LSB]};
    assign o_irq      = |(istat_r & imask_r);

    // Checks, one set per timer
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    for (genvar n = 0; n < N; n++) begin : g_ast
        AST_WRAP13: assert property (
            inc[n] && mode[n] == dtc_pkg::MODE_13 && {th_r[n], tl_r[n][4:0]} == 13'h1fff
            && !wr_tl[n] && !wr_th[n] && !wr_ctrl
            |=> {th_r[n], tl_r[n][4:0]} == 13'h0000 && o_ovf_flag[n])
            else $error("13-bit wrap or flag wrong");
        AST_CARRY13: assert property (
            inc[n] && mode[n] == dtc_pkg::MODE_13 && tl_r[n][4:0] == 5'h1f
            && th_r[n] != 8'hff && !wr_tl[n] && !wr_th[n]
            |=> th_r[n] == $past(th_r[n]) + 8'h01 && tl_r[n][4:0] == 5'h00)
            else $error("13-bit carry missed");
        AST_WRAP16: assert property (
            inc[n] && mode[n] == dtc_pkg::MODE_16 && {th_r[n], tl_r[n]} == 16'hffff
            && !wr_tl[n] && !wr_th[n] && !wr_ctrl
            |=> {th_r[n], tl_r[n]} == 16'h0000 && o_ovf_flag[n])
            else $error("16-bit wrap or flag wrong");
        AST_RELOAD: assert property (
            inc[n] && mode[n] == dtc_pkg::MODE_RELOAD && tl_r[n] == 8'hff && !wr_tl[n]
            |=> tl_r[n] == $past(th_r[n]))
            else $error("reload value not loaded");
        AST_HOLD_TH: assert property (
            mode[n] == dtc_pkg::MODE_RELOAD && !wr_th[n] |=> $stable(th_r[n]))
            else $error("reload byte changed without a write");
        AST_GATE: assert property (
            (!run[n] || (mode_r[n*4 + 3] && !gate_pin[n])) && !wr_tl[n] && !wr_th[n]
            |=> $stable(tl_r[n]) && $stable(th_r[n]))
            else $error("timer moved while gated off");
        AST_PIN_EDGE: assert property (
            inc[n] && mode_r[n*4 + 2] |-> $past(count_pin[n], 4) && $past(count_pin[n], 3)
            && !$past(count_pin[n], 2) && !$past(count_pin[n]))
            else $error("count without filtered falling edge");
        AST_FLAG_HOLD: assert property (
            o_ovf_flag[n] && !i_ovf_ack[n] && !wr_ctrl |=> o_ovf_flag[n])
            else $error("overflow flag dropped by itself");
    end
endmodule // dtc_top
`default_nettype wire

// file: testbench/dual_timer_counter_modes_bench.sv
`default_nettype none
module dual_timer_counter_modes_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, r = 1'b0;
    logic        awrdy, wrdy, bv, arrdy, rv, irq;
    logic [1:0]  bresp, rresp, flag;
    logic [31:0] rdata;
    logic [11:0] aa = 12'h000;
    logic [31:0] wd = 32'h00000000;
    logic [1:0]  gp = 2'h0, cp = 2'h0, ack = 2'h0;
    logic [33:0] exq[$];
    logic [31:0] seed = 32'h00000057;
    logic [7:0]  v;
    int          n_errors = 0;
    int          compares = 0;

    dtc_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(aw), .o_awready(awrdy),
        .i_awaddr(aa), .i_wvalid(w), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'h1),
        .o_bvalid(bv), .i_bready(b), .o_bresp(bresp), .i_arvalid(ar), .o_arready(arrdy),
        .i_araddr(aa), .o_rvalid(rv), .i_rready(r), .o_rdata(rdata), .o_rresp(rresp),
        .i_first_gate_pin(gp[0]), .i_second_gate_pin(gp[1]), .i_first_count_pin(cp[0]),
        .i_second_count_pin(cp[1]), .i_ovf_ack(ack), .o_ovf_flag(flag), .o_irq(irq));

    // 4 ns system clock
    always #2 i_clk = ~i_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One bus transfer; ready decided at negedge so the release lands after the taking edge
    task automatic bus(input logic wrt, input logic [7:0] idx, input logic [7:0] d,
                       input logic [1:0] er);
        logic pa, pw, pb, pr, pv;
        int   n;
        // Fresh edge so the last release is never overwritten in one step
        @(posedge i_clk);
        {pa, pw, pb} = {3{wrt}};
        {pr, pv} = {2{!wrt}};
        exq.push_back(wrt ? {er, 32'h00000000} : {er, 24'h000000, d});
        aa <= {2'h0, idx, 2'h0};
        wd <= {24'h000000, d};
        {aw, w, b, ar, r} <= {pa, pw, pb, pr, pv};
        for (n = 0; n < 50 && (pb || pv); n++) begin
            @(negedge i_clk);
            {pa, pw, pb} = {pa && !awrdy, pw && !wrdy, pb && !bv};
            {pr, pv} = {pr && !arrdy, pv && !rv};
            @(posedge i_clk);
            {aw, w, b, ar, r} <= {pa, pw, pb, pr, pv};
        end
        if (pb || pv) begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, dtc_pkg::RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b0, idx, d, dtc_pkg::RESP_OKAY);
    endtask

    // Count pin pulse; four low cycles let the edge filter finish
    task automatic pulse(input logic [1:0] m, input int hi, input int lo);
        cp <= m;
        repeat (hi) @(posedge i_clk);
        cp <= 2'h0;
        repeat (lo) @(posedge i_clk);
    endtask

    // Gate pins high for exactly k sampling edges
    task automatic open_gate(input int k);
        gp <= 2'h3;
        repeat (k) @(posedge i_clk);
        gp <= 2'h0;
    endtask

    task automatic see(input logic [2:0] e);
        @(negedge i_clk);
        check(34'({flag, irq}), 34'(e));
    endtask

    // Response checker: oldest note against each completed response
    always @(posedge i_clk) begin
        if ((bv && b) || (rv && r)) begin
            if (exq.size() == 0)
                n_errors++;
            else
                check((bv && b) ? {bresp, 32'h00000000} : {rresp, rdata}, exq.pop_front());
        end
    end

    // Counter mode until the last section, but for timer two in the gate section, so the checked counts are pin-driven and exact
    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        rd(dtc_pkg::IDX_MODE, 8'h00);
        bus(1'b0, 8'h8f, 8'h00, dtc_pkg::RESP_SLVERR);
        wr(dtc_pkg::IDX_MODE, 8'h44);
        wr(dtc_pkg::IDX_TL0, 8'h1e);
        wr(dtc_pkg::IDX_TH0, 8'hff);
        wr(dtc_pkg::IDX_TL1, 8'h1f);
        wr(dtc_pkg::IDX_TH1, 8'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        pulse(2'h3, 2, 4);
        pulse(2'h1, 2, 4);
        rd(dtc_pkg::IDX_TH0, 8'h00);
        rd(dtc_pkg::IDX_TL0, 8'h00);
        rd(dtc_pkg::IDX_TH1, 8'h01);
        rd(dtc_pkg::IDX_TL1, 8'h00);
        rd(dtc_pkg::IDX_CTRL, 8'h70);
        see(3'b010);
        wr(dtc_pkg::IDX_IMASK, 8'h01);
        see(3'b011);
        rd(dtc_pkg::IDX_ISTAT, 8'h01);
        rd(dtc_pkg::IDX_ISTAT, 8'h00);
        see(3'b010);
        @(posedge i_clk);
        ack <= 2'h1;
        @(posedge i_clk);
        ack <= 2'h0;
        see(3'b000);
        // Gate low, short glitch, valid pulse, then run bit off
        wr(dtc_pkg::IDX_MODE, 8'h0d);
        wr(dtc_pkg::IDX_TL0, 8'h00);
        pulse(2'h1, 2, 4);
        gp <= 2'h1;
        pulse(2'h1, 1, 4);
        pulse(2'h1, 2, 4);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        pulse(2'h1, 2, 4);
        rd(dtc_pkg::IDX_TL0, 8'h01);
        // 16-bit: full low byte chains, timer two wraps
        wr(dtc_pkg::IDX_MODE, 8'h55);
        wr(dtc_pkg::IDX_TL0, 8'h3f);
        wr(dtc_pkg::IDX_TH0, 8'h00);
        wr(dtc_pkg::IDX_TL1, 8'hff);
        wr(dtc_pkg::IDX_TH1, 8'hff);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        pulse(2'h3, 2, 4);
        rd(dtc_pkg::IDX_TL0, 8'h40);
        rd(dtc_pkg::IDX_TH0, 8'h00);
        rd(dtc_pkg::IDX_TL1, 8'h00);
        rd(dtc_pkg::IDX_TH1, 8'h00);
        see(3'b100);
        // Reload: random start kept below the wrap for timer two
        v = {1'b0, 7'(rnd() >> 25)};
        wr(dtc_pkg::IDX_MODE, 8'h66);
        wr(dtc_pkg::IDX_TL0, 8'hfe);
        wr(dtc_pkg::IDX_TH0, 8'hfe);
        wr(dtc_pkg::IDX_TL1, v);
        wr(dtc_pkg::IDX_TH1, v);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        pulse(2'h3, 2, 4);
        pulse(2'h1, 2, 4);
        rd(dtc_pkg::IDX_TL0, 8'hfe);
        rd(dtc_pkg::IDX_TH0, 8'hfe);
        rd(dtc_pkg::IDX_TL1, v + 8'h01);
        rd(dtc_pkg::IDX_TH1, v);
        see(3'b011);
        // Timer mode: a gated window of known length gives exact tick counts
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        gp <= 2'h0;
        wr(dtc_pkg::IDX_MODE, 8'h99);
        wr(dtc_pkg::IDX_CKSPD, 8'h08);
        wr(dtc_pkg::IDX_CKDIV, 8'h10);
        wr(dtc_pkg::IDX_TL0, 8'h00);
        wr(dtc_pkg::IDX_TL1, 8'h00);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        open_gate(8);
        rd(dtc_pkg::IDX_TL0, 8'h08);
        rd(dtc_pkg::IDX_TL1, 8'h02);
        wr(dtc_pkg::IDX_PWR, 8'hc0);
        open_gate(2048);
        rd(dtc_pkg::IDX_TL0, 8'h0a);
        rd(dtc_pkg::IDX_TL1, 8'h04);
        final_report();
    end
endmodule // dual_timer_counter_modes_bench
`default_nettype wire
